// File: hw/lane_conditioning_config_regs.sv
// Channel 1 lane conditioning register bank plus a channel 2 idle/speed register, with decoded analog controls.
`timescale 1ns/1ns
module lane_conditioning_config_regs
   import lane_cfg_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic wr_en_i,         // One-cycle write strobe
   input wire logic [7:0] addr_i,    // Register offset
   input wire logic [7:0] wdata_i,   // Write data
   output logic [7:0] rdata_o,       // Registered read data
   output logic output_idle_o,       // Lane output forced to electrical idle
   output logic auto_idle_en_o,      // Automatic idle detection enabled
   output logic signal_presence_squelch_en_o, // Squelch active
   output logic auto_rate_en_o,      // Automatic rate detection enabled
   output logic high_rate_sel_o,     // 1: 5.0-6.4 Gbps, 0: 2.5-3.2 Gbps
   output logic ch2_auto_idle_en_o,
   output logic ch2_idle_man_o,
   output logic ch2_auto_rate_en_o,
   output logic ch2_rate_man_o,
   output logic eq_enable_o,
   output logic [1:0] gain_stage_sel_o,
   output logic [2:0] boost_level_sel_o,
   output logic eq_is_strap_code_o,  // Equalizer code matches a strap setting
   output logic [5:0] output_swing_o,
   output logic [10:0] output_swing_mv_o, // 0 when code is not a listed one
   output logic emphasis_style_o,    // 0 compatibility, 1 enhanced
   output logic [6:0] emph_level_o,
   output logic emph_code_reserved_o, // Reserved de-emphasis code held
   output logic [7:0] idle_deassert_mv_o,
   output logic [7:0] idle_assert_mv_o
);
   // ==========================================================
   // Register storage
   logic [7:0] ch1_idle_and_speed_select_reg;
   logic [7:0] ch1_rx_equalizer_ctrl_reg;
   logic [7:0] ch1_tx_swing_ctrl_reg;
   logic [7:0] ch1_tx_deemphasis_ctrl_reg;
   logic [7:0] ch1_idle_threshold_reg;
   logic [7:0] ch2_idle_and_speed_select_reg;
   logic [7:0] rdata_next;
   logic [7:0] deassert_mv; // Decoder results, registered before leaving
   logic [7:0] assert_mv;

   // Write helper: does this strobe hit the given offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Is the equalizer code one of the nine strap settings
   function automatic logic is_strap(input logic [5:0] c);
      is_strap = 1'b0;
      for (int k = 0; k < 9; k++) begin
         if (c == EQ_STRAP_CODES[k]) begin
            is_strap = 1'b1;
         end
      end
   endfunction : is_strap

   // ==========================================================
   // Register writes; reserved bits are masked so they stay zero.
   // Values take effect the edge after the write, no commit step.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ch1_idle_and_speed_select_reg <= RST_IDLE_SPEED;
         ch1_rx_equalizer_ctrl_reg <= RST_RX_EQ;
         ch1_tx_swing_ctrl_reg <= RST_TX_SWING;
         ch1_tx_deemphasis_ctrl_reg <= RST_TX_DEEMPH;
         ch1_idle_threshold_reg <= RST_IDLE_THR;
         ch2_idle_and_speed_select_reg <= RST_IDLE_SPEED;
      end else if (wr_en_i) begin
         if (hit(addr_i, ADDR_CH1_IDLE_SPEED)) begin
            ch1_idle_and_speed_select_reg <= wdata_i & MASK_IDLE_SPEED;
         end
         if (hit(addr_i, ADDR_CH1_RX_EQ)) begin
            ch1_rx_equalizer_ctrl_reg <= wdata_i & MASK_RX_EQ;
         end
         if (hit(addr_i, ADDR_CH1_TX_SWING)) begin
            ch1_tx_swing_ctrl_reg <= wdata_i & MASK_TX_SWING;
         end
         if (hit(addr_i, ADDR_CH1_TX_DEEMPH)) begin
            ch1_tx_deemphasis_ctrl_reg <= wdata_i & MASK_TX_DEEMPH;
         end
         if (hit(addr_i, ADDR_CH1_IDLE_THR)) begin
            ch1_idle_threshold_reg <= wdata_i & MASK_IDLE_THR;
         end
         if (hit(addr_i, ADDR_CH2_IDLE_SPEED)) begin
            ch2_idle_and_speed_select_reg <= wdata_i & MASK_IDLE_SPEED;
         end
      end
   end

   // ==========================================================
   // Read mux; unmapped offsets read zero
   always_comb begin
      case (addr_i)
         ADDR_CH1_IDLE_SPEED: rdata_next = ch1_idle_and_speed_select_reg;
         ADDR_CH1_RX_EQ: rdata_next = ch1_rx_equalizer_ctrl_reg;
         ADDR_CH1_TX_SWING: rdata_next = ch1_tx_swing_ctrl_reg;
         ADDR_CH1_TX_DEEMPH: rdata_next = ch1_tx_deemphasis_ctrl_reg;
         ADDR_CH1_IDLE_THR: rdata_next = ch1_idle_threshold_reg;
         ADDR_CH2_IDLE_SPEED: rdata_next = ch2_idle_and_speed_select_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // Read data is registered: valid one edge after the address
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rdata_next;
      end
   end

   // ==========================================================
   // Idle and rate controls. Manual idle only governs while automatic
   // idle detection is off; in auto mode the detector owns the mute.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         output_idle_o <= 1'b0;
         auto_idle_en_o <= 1'b0;
         signal_presence_squelch_en_o <= 1'b0;
         auto_rate_en_o <= 1'b0;
         high_rate_sel_o <= 1'b0;
         ch2_auto_idle_en_o <= 1'b0;
         ch2_idle_man_o <= 1'b0;
         ch2_auto_rate_en_o <= 1'b0;
         ch2_rate_man_o <= 1'b0;
      end else begin
         auto_idle_en_o <= ch1_idle_and_speed_select_reg[BIT_IDLE_AUTO];
         output_idle_o <= !ch1_idle_and_speed_select_reg[BIT_IDLE_AUTO]
                          && ch1_idle_and_speed_select_reg[BIT_IDLE_MAN];
         // Squelch is off while manual mode holds the output on
         signal_presence_squelch_en_o <= ch1_idle_and_speed_select_reg[BIT_IDLE_AUTO];
         auto_rate_en_o <= ch1_idle_and_speed_select_reg[BIT_RATE_AUTO];
         // Manual rate is only meaningful with auto rate off; forced low otherwise
         high_rate_sel_o <= !ch1_idle_and_speed_select_reg[BIT_RATE_AUTO]
                            && ch1_idle_and_speed_select_reg[BIT_RATE_MAN];
         ch2_auto_idle_en_o <= ch2_idle_and_speed_select_reg[BIT_IDLE_AUTO];
         ch2_idle_man_o <= ch2_idle_and_speed_select_reg[BIT_IDLE_MAN];
         ch2_auto_rate_en_o <= ch2_idle_and_speed_select_reg[BIT_RATE_AUTO];
         ch2_rate_man_o <= ch2_idle_and_speed_select_reg[BIT_RATE_MAN];
      end
   end

   // ==========================================================
   // Equalizer field split
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         eq_enable_o <= 1'b1;
         gain_stage_sel_o <= 2'h0;
         boost_level_sel_o <= 3'h0;
         eq_is_strap_code_o <= 1'b1;
      end else begin
         eq_enable_o <= ch1_rx_equalizer_ctrl_reg[BIT_EQ_EN];
         gain_stage_sel_o <= ch1_rx_equalizer_ctrl_reg[4:3];
         boost_level_sel_o <= ch1_rx_equalizer_ctrl_reg[2:0];
         eq_is_strap_code_o <= is_strap(ch1_rx_equalizer_ctrl_reg[5:0]);
      end
   end

   // ==========================================================
   // Output swing; unlisted codes pass through but report 0 mV
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         output_swing_o <= 6'h03;
         output_swing_mv_o <= 11'h258;
      end else begin
         output_swing_o <= ch1_tx_swing_ctrl_reg[5:0];
         case (ch1_tx_swing_ctrl_reg[5:0])
            6'h03: output_swing_mv_o <= 11'h258; // 600 mV
            6'h07: output_swing_mv_o <= 11'h320; // 800 mV
            6'h0F: output_swing_mv_o <= 11'h3E8; // 1000 mV
            6'h1F: output_swing_mv_o <= 11'h4B0; // 1200 mV
            6'h3F: output_swing_mv_o <= 11'h578; // 1400 mV
            default: output_swing_mv_o <= 11'h000;
         endcase
      end
   end

   // ==========================================================
   // De-emphasis split. The reserved code is flagged, not blocked,
   // so software can see it misprogrammed the lane.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         emphasis_style_o <= 1'b0;
         emph_level_o <= 7'h03;
         emph_code_reserved_o <= 1'b0;
      end else begin
         emphasis_style_o <= ch1_tx_deemphasis_ctrl_reg[BIT_EMPH_STYLE];
         emph_level_o <= ch1_tx_deemphasis_ctrl_reg[6:0];
         emph_code_reserved_o <= (ch1_tx_deemphasis_ctrl_reg == EMPH_RESERVED_CODE);
      end
   end

   // ==========================================================
   // Idle thresholds: de-assert and assert codes decoded separately
   thr_pair_decode u_deassert_dec (
      .code_i(ch1_idle_threshold_reg[3:2]),
      .deassert_mv_o(deassert_mv),
      .assert_mv_o()
   );
   thr_pair_decode u_assert_dec (
      .code_i(ch1_idle_threshold_reg[1:0]),
      .deassert_mv_o(),
      .assert_mv_o(assert_mv)
   );

   // Register the decoded thresholds
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idle_deassert_mv_o <= 8'h6E;
         idle_assert_mv_o <= 8'h46;
      end else begin
         idle_deassert_mv_o <= deassert_mv;
         idle_assert_mv_o <= assert_mv;
      end
   end
endmodule : lane_conditioning_config_regs

// File: hw/lane_cfg_pkg.sv
// Constants for the lane conditioning configuration register bank.
// Function
// - Manual idle bit forces output electrical idle while auto idle is off
// - Auto idle bit selects automatic idle detection
// - Auto rate bit overrides manual rate select on channel 1; channel 2 outputs both rate bits unmasked
// - Equalizer field: enable, gain stage, boost
// - Equalizer resets to bypass; nine strap codes
// - Output swing codes map to five levels
// - De-emphasis bit 7 style, bits 6:0 level
// - De-emphasis codes; code C0h is reserved
// - Idle nibble: de-assert 3:2, assert 1:0
// - Two-bit threshold code picks threshold pair
package lane_cfg_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_CH1_IDLE_SPEED = 8'h15;
   localparam logic [7:0] ADDR_CH1_RX_EQ = 8'h16;
   localparam logic [7:0] ADDR_CH1_TX_SWING = 8'h17;
   localparam logic [7:0] ADDR_CH1_TX_DEEMPH = 8'h18;
   localparam logic [7:0] ADDR_CH1_IDLE_THR = 8'h19;
   localparam logic [7:0] ADDR_CH2_IDLE_SPEED = 8'h1C;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_IDLE_SPEED = 8'h00;
   localparam logic [7:0] RST_RX_EQ = 8'h20;
   localparam logic [7:0] RST_TX_SWING = 8'h03;
   localparam logic [7:0] RST_TX_DEEMPH = 8'h03;
   localparam logic [7:0] RST_IDLE_THR = 8'h00;
   // ==========================================================
   // Writable bit masks (reserved bits read zero)
   localparam logic [7:0] MASK_IDLE_SPEED = 8'h33;
   localparam logic [7:0] MASK_RX_EQ = 8'h3F;
   localparam logic [7:0] MASK_TX_SWING = 8'h3F;
   localparam logic [7:0] MASK_TX_DEEMPH = 8'hFF;
   localparam logic [7:0] MASK_IDLE_THR = 8'h0F;
   // ==========================================================
   // Field positions
   localparam int BIT_RATE_MAN = 0;
   localparam int BIT_RATE_AUTO = 1;
   localparam int BIT_IDLE_MAN = 4;
   localparam int BIT_IDLE_AUTO = 5;
   localparam int BIT_EQ_EN = 5;
   localparam int BIT_EMPH_STYLE = 7;
   // ==========================================================
   // Notable codes
   localparam logic [7:0] EMPH_RESERVED_CODE = 8'hC0;
   localparam logic [5:0] EQ_BYPASS_CODE = 6'h20;
   // Pin-strap equalizer table, index = {eq_strap_hi, eq_strap_lo} style 0..8
   localparam logic [5:0] EQ_STRAP_CODES [9] = '{6'h20, 6'h2A, 6'h30, 6'h31, 6'h38,
                                                 6'h34, 6'h35, 6'h3A, 6'h3C};
endpackage : lane_cfg_pkg

// File: hw/thr_pair_decode.sv
// Idle threshold code to millivolt pair decoder.
`timescale 1ns/1ns
module thr_pair_decode (
   input wire logic [1:0] code_i,
   output logic [7:0] deassert_mv_o,
   output logic [7:0] assert_mv_o
);
   // ==========================================================
   // Decode one two-bit code into de-assert/assert millivolts
   always_comb begin
      case (code_i)
         2'b00: begin
            deassert_mv_o = 8'h6E; // 110 mV, reset choice
            assert_mv_o = 8'h46;   // 70 mV
         end
         2'b01: begin
            deassert_mv_o = 8'h96; // 150 mV
            assert_mv_o = 8'h6E;   // 110 mV
         end
         2'b10: begin
            deassert_mv_o = 8'hAA; // 170 mV
            assert_mv_o = 8'h82;   // 130 mV
         end
         default: begin
            deassert_mv_o = 8'hBE; // 190 mV
            assert_mv_o = 8'h96;   // 150 mV
         end
      endcase
   end
endmodule : thr_pair_decode

// File: bench/lane_cfg_props.sv
// Port-level checker for the lane conditioning register bank.
`timescale 1ns/1ns
// ============================================================
// Checker
module lane_cfg_props
   import lane_cfg_pkg::*;
(
   input wire logic core_clk_i, reset_n_i, wr_en_i,
   input wire logic [7:0] addr_i, wdata_i,
   input wire logic output_idle_o, auto_idle_en_o, signal_presence_squelch_en_o,
   input wire logic auto_rate_en_o, high_rate_sel_o, eq_enable_o, eq_is_strap_code_o,
   input wire logic [1:0] gain_stage_sel_o,
   input wire logic [2:0] boost_level_sel_o,
   input wire logic [10:0] output_swing_mv_o,
   input wire logic emphasis_style_o, emph_code_reserved_o,
   input wire logic [6:0] emph_level_o,
   input wire logic [7:0] idle_deassert_mv_o, idle_assert_mv_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Write strobes per register; decoded outputs show a write two edges later
   wire wr_idle = wr_en_i && addr_i == ADDR_CH1_IDLE_SPEED;
   wire wr_eq = wr_en_i && addr_i == ADDR_CH1_RX_EQ;
   wire wr_emph = wr_en_i && addr_i == ADDR_CH1_TX_DEEMPH;
   property p_idle_forced;
      wr_idle && wdata_i[5:4] == 2'h1 |-> ##2 output_idle_o && !signal_presence_squelch_en_o;
   endproperty
   a_idle_forced: assert property (p_idle_forced) else $error("idle not forced");
   property p_idle_auto;
      wr_idle && wdata_i[5] |-> ##2 auto_idle_en_o && signal_presence_squelch_en_o
         && !output_idle_o;
   endproperty
   a_idle_auto: assert property (p_idle_auto) else $error("auto idle wrong");
   property p_rate;
      wr_idle |-> ##2 auto_rate_en_o == $past(wdata_i[1], 2)
         && high_rate_sel_o == ($past(wdata_i[0], 2) && !$past(wdata_i[1], 2));
   endproperty
   a_rate: assert property (p_rate) else $error("rate select wrong");
   property p_eq_fields;
      wr_eq |-> ##2 {eq_enable_o, gain_stage_sel_o, boost_level_sel_o} == $past(wdata_i[5:0], 2);
   endproperty
   a_eq_fields: assert property (p_eq_fields) else $error("eq fields wrong");
   property p_swing_top;
      wr_en_i && addr_i == ADDR_CH1_TX_SWING && wdata_i[5:0] == 6'h3F
         |-> ##2 output_swing_mv_o == 11'h578;
   endproperty
   a_swing_top: assert property (p_swing_top) else $error("swing mV wrong");
   property p_emph;
      wr_emph |-> ##2 emphasis_style_o == $past(wdata_i[7], 2) && emph_level_o ==
         $past(wdata_i[6:0], 2) && emph_code_reserved_o == ($past(wdata_i, 2) == 8'hC0);
   endproperty
   a_emph: assert property (p_emph) else $error("de-emphasis wrong");
   property p_thr;
      wr_en_i && addr_i == ADDR_CH1_IDLE_THR && wdata_i[3:0] == 4'hE
         |-> ##2 idle_deassert_mv_o == 8'hBE && idle_assert_mv_o == 8'h82;
   endproperty
   a_thr: assert property (p_thr) else $error("threshold pair wrong");
   // Without a write the swing millivolts and de-emphasis level must not drift
   property p_hold;
      !wr_en_i |-> ##2 $stable(output_swing_mv_o) && $stable(emph_level_o);
   endproperty
   a_hold: assert property (p_hold) else $error("control moved without write");
   c_idle: cover property (wr_idle && wdata_i[4]);
   c_resv: cover property (wr_emph && wdata_i == 8'hC0);
   c_eq: cover property (wr_eq && wdata_i[5:0] == 6'h3C);
endmodule : lane_cfg_props
bind lane_conditioning_config_regs lane_cfg_props i_lane_cfg_props (.core_clk_i, .reset_n_i,
   .wr_en_i, .addr_i, .wdata_i, .output_idle_o, .auto_idle_en_o, .signal_presence_squelch_en_o,
   .auto_rate_en_o, .high_rate_sel_o, .eq_enable_o, .eq_is_strap_code_o, .gain_stage_sel_o,
   .boost_level_sel_o, .output_swing_mv_o, .emphasis_style_o, .emph_code_reserved_o,
   .emph_level_o, .idle_deassert_mv_o, .idle_assert_mv_o);

// File: bench/mgmt_host_model.sv
// Management host model driving single-byte register accesses.
`timescale 1ns/1ns
// ============================================================
// Host
module mgmt_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic wr_en_o = 1'b0,
   output logic [7:0] addr_o = 8'h00,
   output logic [7:0] wdata_o = 8'h00
);
   // Strobe stays up, so calls may follow back to back
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      wr_en_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(negedge clk_i);
   endtask : write_reg
   // Released data is inverted so a stale byte never looks valid
   task automatic idle_bus();
      wr_en_o <= 1'b0;
      wdata_o <= ~wdata_o;
      @(negedge clk_i);
   endtask : idle_bus
   // Read data shows the offset one edge later
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      addr_o <= a;
      idle_bus();
      d = rdata_i;
   endtask : read_reg
endmodule : mgmt_host_model

// File: bench/lane_conditioning_config_regs_tb_top.sv
// Self-checking bench for the lane conditioning register bank.
`timescale 1ns/1ns
// ============================================================
// Bench top
module lane_conditioning_config_regs_tb_top;
   import lane_cfg_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wr_en_i, output_idle_o, auto_idle_en_o, signal_presence_squelch_en_o;
   logic auto_rate_en_o, high_rate_sel_o, ch2_auto_idle_en_o, ch2_idle_man_o;
   logic ch2_auto_rate_en_o, ch2_rate_man_o, eq_enable_o, eq_is_strap_code_o;
   logic emphasis_style_o, emph_code_reserved_o;
   logic [1:0] gain_stage_sel_o;
   logic [2:0] boost_level_sel_o;
   logic [5:0] output_swing_o, cw;
   logic [6:0] emph_level_o;
   logic [7:0] addr_i, wdata_i, rdata_o, idle_deassert_mv_o, idle_assert_mv_o, rd;
   logic [10:0] output_swing_mv_o;
   int num_errors = 0;
   int checks_done = 0;
   // Offsets, reset values and writable masks; 1Ah is unmapped
   logic [7:0] adr [7] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1C, 8'h1A};
   logic [7:0] rst [7] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};
   logic [7:0] msk [7] = '{8'h33, 8'h3F, 8'h3F, 8'hFF, 8'h0F, 8'h33, 8'h00};
   logic [5:0] strap [9] = '{6'h20, 6'h2A, 6'h30, 6'h31, 6'h38, 6'h34, 6'h35, 6'h3A, 6'h3C};
   // Swing codes and millivolts; 05h is not a listed code
   logic [5:0] sw_code [6] = '{6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F, 6'h05};
   logic [10:0] sw_mv [6] = '{11'h258, 11'h320, 11'h3E8, 11'h4B0, 11'h578, 11'h000};
   logic [7:0] emph [6] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0, 8'hC0};
   logic [7:0] thr_de [4] = '{8'h6E, 8'h96, 8'hAA, 8'hBE};
   logic [7:0] thr_as [4] = '{8'h46, 8'h6E, 8'h82, 8'h96};
   // Idle/speed byte against {idle, auto idle, squelch, auto rate, high rate}
   logic [7:0] mode [5] = '{8'h10, 8'h30, 8'h01, 8'h03, 8'h00};
   logic [4:0] mode_exp [5] = '{5'h10, 5'h0C, 5'h01, 5'h02, 5'h00};
   wire [4:0] mode_v = {output_idle_o, auto_idle_en_o, signal_presence_squelch_en_o,
      auto_rate_en_o, high_rate_sel_o};
   lane_conditioning_config_regs i_lane_conditioning_config_regs (.core_clk_i, .reset_n_i,
      .wr_en_i, .addr_i, .wdata_i, .rdata_o, .output_idle_o, .auto_idle_en_o,
      .signal_presence_squelch_en_o, .auto_rate_en_o, .high_rate_sel_o, .ch2_auto_idle_en_o,
      .ch2_idle_man_o, .ch2_auto_rate_en_o, .ch2_rate_man_o, .eq_enable_o, .gain_stage_sel_o,
      .boost_level_sel_o, .eq_is_strap_code_o, .output_swing_o, .output_swing_mv_o,
      .emphasis_style_o, .emph_level_o, .emph_code_reserved_o, .idle_deassert_mv_o,
      .idle_assert_mv_o);
   mgmt_host_model i_mgmt_host_model (.clk_i(core_clk_i), .rdata_i(rdata_o),
      .wr_en_o(wr_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
   always #20 core_clk_i = ~core_clk_i;
   task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic final_report();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report
   // Write, then let the decoded controls settle one more edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_mgmt_host_model.write_reg(a, d);
      i_mgmt_host_model.idle_bus();
   endtask : wr
   // A hang is cut short as a mismatch
   initial begin
      repeat (2000) @(posedge core_clk_i);
      num_errors++;
      final_report();
   end
   initial begin
      repeat (2) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      for (int i = 0; i < 7; i++) begin
         i_mgmt_host_model.read_reg(adr[i], rd);
         check("reset value", rd, rst[i]);
      end
      check("swing mV", output_swing_mv_o, 11'h258);
      check("reset deassert mV", idle_deassert_mv_o, 11'h06E);
      check("reset assert mV", idle_assert_mv_o, 11'h046);
      // Back-to-back all-ones writes land masked; the unmapped one is dropped
      for (int i = 0; i < 7; i++) i_mgmt_host_model.write_reg(adr[i], 8'hFF);
      for (int i = 0; i < 7; i++) begin
         i_mgmt_host_model.read_reg(adr[i], rd);
         check("masked write", rd, msk[i]);
      end
      check("ch2 bits", {ch2_auto_idle_en_o, ch2_idle_man_o, ch2_auto_rate_en_o,
         ch2_rate_man_o}, 11'h00F);
      // Mixed pattern so a swapped channel 2 bit cannot hide behind all ones
      wr(ADDR_CH2_IDLE_SPEED, 8'h12);
      check("ch2 mixed bits", {ch2_auto_idle_en_o, ch2_idle_man_o, ch2_auto_rate_en_o,
         ch2_rate_man_o}, 11'h006);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CH1_IDLE_SPEED, mode[i]);
         check("idle and rate", mode_v, mode_exp[i]);
      end
      for (int i = 0; i < 10; i++) begin
         cw = (i < 9) ? strap[i] : 6'h21;
         wr(ADDR_CH1_RX_EQ, {2'h0, cw});
         check("strap flag", eq_is_strap_code_o, i < 9);
         check("eq fields", {eq_enable_o, gain_stage_sel_o, boost_level_sel_o}, cw);
      end
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_CH1_TX_SWING, {2'h0, sw_code[i]});
         check("swing mV", output_swing_mv_o, sw_mv[i]);
         check("swing code", output_swing_o, sw_code[i]);
      end
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_CH1_TX_DEEMPH, emph[i]);
         check("emph style", emphasis_style_o, emph[i][7]);
         check("emph level", emph_level_o, emph[i][6:0]);
         check("reserved flag", emph_code_reserved_o, emph[i] == 8'hC0);
      end
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_CH1_IDLE_THR, 8'(i));
         check("deassert mV", idle_deassert_mv_o, thr_de[i / 4]);
         check("assert mV", idle_assert_mv_o, thr_as[i % 4]);
      end
      // Reset in mid-run restores the default swing
      reset_n_i = 1'b0;
      @(negedge core_clk_i);
      reset_n_i = 1'b1;
      i_mgmt_host_model.read_reg(ADDR_CH1_TX_SWING, rd);
      check("swing reset", rd, 8'h03);
      check("swing mV after reset", output_swing_mv_o, 11'h258);
      check("deassert mV after reset", idle_deassert_mv_o, 11'h06E);
      check("assert mV after reset", idle_assert_mv_o, 11'h046);
      final_report();
   end
endmodule : lane_conditioning_config_regs_tb_top
